// *** core/psm_consts.svh ***
// Constants for the power-saving mode controller: codes, fields, offsets and counts.
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH
`define PSM_CODE_SLEEP 8'h0F
`define PSM_CODE_STOP 8'h5A
`define PSM_CODE_RST 8'h00
`define PSM_CKCTL_RST 8'h00
`define PSM_CK_RC_WATCHDOG_SELECT_BIT 5
`define PSM_CK_WDTRST_BIT 4
`define PSM_CK_PRESC_MSB 2
`define PSM_CK_PRESC_LSB 0
`define PSM_STAB_FIRST 8'h00
`define PSM_STAB_LAST 8'hFF
`define PSM_REG_CODE 4'h0
`define PSM_REG_CKCTL 4'h4
`define PSM_REG_CTRL 4'h8
`define PSM_REG_STAT 4'hC
`define PSM_CTRL_STOP_BIT 0
`define PSM_CTRL_IFLAG_BIT 1
`define PSM_CTRL_WDTIE_BIT 2
`define PSM_CTRL_EVCNT_BIT 3
`define PSM_CTRL_SIOEXT_BIT 4
`define PSM_CTRL_U0EXT_BIT 5
`define PSM_CTRL_U1EXT_BIT 6
`define PSM_STAT_RESUME_BIT 4
`define PSM_STAT_VECTOR_BIT 5
`define PSM_STAT_WDTVEC_BIT 6
`define PSM_STAT_INTRST_BIT 7
`define PSM_AXI_OKAY 2'h0
`define PSM_AXI_SLVERR 2'h2
`endif

// *** core/psm_pkg.sv ***
// Types shared by both ends of the power-saving mode controller.
package psm_pkg;
   typedef enum logic [3:0] {
      PSM_RUN = 4'h1,
      PSM_SLEEP = 4'h2,
      PSM_STOP = 4'h4,
      PSM_STAB = 4'h8
   } psm_state_t;
   typedef enum logic [1:0] {
      PSM_MODE_RUN = 2'h0,
      PSM_MODE_SLEEP = 2'h1,
      PSM_MODE_STOP = 2'h2,
      PSM_MODE_STAB = 2'h3
   } psm_mode_t;
endpackage : psm_pkg

// *** core/psm_if.sv ***
// Interface joining the processor-core end and the power controller end.
`timescale 1ns/10ps
interface psm_if;
   logic code_wr;
   logic [7:0] code_data;
   logic ckctl_wr;
   logic [7:0] ckctl_data;
   logic stop_exec;
   logic i_flag;
   logic wdt_irq_en;
   logic tmr_event_mode;
   logic sio_ext;
   logic uart0_ext;
   logic uart1_ext;
   logic wake_any;
   logic wake_ext;
   logic wake_ec;
   logic wake_watch;
   logic wake_wdt;
   logic wake_sio;
   logic wake_uart;
   psm_pkg::psm_mode_t mode;
   logic resume;
   logic vector_req;
   logic wdt_vector;
   logic int_reset;
   modport dev (
      input code_wr, code_data, ckctl_wr, ckctl_data, stop_exec, i_flag, wdt_irq_en,
      input tmr_event_mode, sio_ext, uart0_ext, uart1_ext,
      input wake_any, wake_ext, wake_ec, wake_watch, wake_wdt, wake_sio, wake_uart,
      output mode, resume, vector_req, wdt_vector, int_reset
   );
   modport core (
      output code_wr, code_data, ckctl_wr, ckctl_data, stop_exec, i_flag, wdt_irq_en,
      output tmr_event_mode, sio_ext, uart0_ext, uart1_ext,
      output wake_any, wake_ext, wake_ec, wake_watch, wake_wdt, wake_sio, wake_uart,
      input mode, resume, vector_req, wdt_vector, int_reset
   );
endinterface : psm_if

// *** core/psm_stab_cnt.sv ***
// Oscillator-stabilisation counter with a selectable prescaler.
`timescale 1ns/10ps
`include "psm_consts.svh"
module psm_stab_cnt #(
   parameter int PRE_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic [2:0] presc_sel,
   output logic busy,
   output logic done
);
   logic [PRE_W-1:0] pre_q;
   logic [7:0] cnt_q;
   logic tick;

   // True when the low sel+1 prescaler bits are all ones.
   function automatic logic pre_tick(input logic [PRE_W-1:0] pre, input logic [2:0] sel);
      logic [PRE_W-1:0] m;
      m = {PRE_W{1'b1}} >> (PRE_W - 1 - int'(sel));
      return (pre & m) == m;
   endfunction : pre_tick

   assign tick = busy && pre_tick(pre_q, presc_sel);

   // Prescaler runs only while a stabilisation wait is in progress.
   always_ff @(posedge aclk) begin
      if (!aresetn || start || !busy) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // Count climbs from 00 and ends with a one-cycle done at overflow.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= `PSM_STAB_FIRST;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_q <= `PSM_STAB_FIRST;
            busy <= 1'b1;
         end else if (tick) begin
            if (cnt_q == `PSM_STAB_LAST) begin
               cnt_q <= `PSM_STAB_FIRST;
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 8'h01;
            end
         end
      end
   end
endmodule : psm_stab_cnt

// *** core/psm_dev_end.sv ***
// Power controller end: mode state machine, wake decoding and clock gating.
`timescale 1ns/10ps
`include "psm_consts.svh"
module psm_dev_end (
   input wire logic aclk,
   input wire logic aresetn,
   psm_if.dev bus,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic main_osc_en,
   output logic sub_osc_en,
   output logic rc_osc_en,
   output logic wdt_run,
   output logic bit_run,
   output logic timer_run,
   output logic sio_run,
   output logic uart0_run,
   output logic uart1_run,
   output logic state_hold,
   output logic pc_hold
);
   psm_pkg::psm_state_t state_q;
   psm_pkg::psm_state_t state_d;
   logic [7:0] code_q;
   logic [7:0] ckctl_q;
   logic wdt_wake_q;
   logic rc_mode;
   logic stop_wake;
   logic stab_start;
   logic stab_done;

   assign rc_mode = ckctl_q[`PSM_CK_RC_WATCHDOG_SELECT_BIT];

   // STOP wake sources narrow to external and watchdog in the RC variant.
   always_comb begin
      if (rc_mode) begin
         stop_wake = bus.wake_ext || bus.wake_wdt;
      end else begin
         stop_wake = bus.wake_ext || bus.wake_ec || bus.wake_watch || bus.wake_wdt
                     || bus.wake_sio || bus.wake_uart;
      end
   end

   // Code and clock control registers; internal reset reinitialises them.
   always_ff @(posedge aclk) begin
      if (!aresetn || bus.int_reset) begin
         code_q <= `PSM_CODE_RST;
         ckctl_q <= `PSM_CKCTL_RST;
      end else begin
         if (bus.code_wr) begin
            code_q <= bus.code_data;
         end
         if (bus.ckctl_wr) begin
            ckctl_q <= bus.ckctl_data;
         end
      end
   end

   // Next mode from the current mode, requests and wake events.
   always_comb begin
      state_d = state_q;
      case (state_q)
         psm_pkg::PSM_RUN: begin
            if (bus.code_wr && bus.code_data == `PSM_CODE_SLEEP) begin
               state_d = psm_pkg::PSM_SLEEP;
            end else if (bus.stop_exec && code_q == `PSM_CODE_STOP) begin
               state_d = psm_pkg::PSM_STOP;
            end else begin
               state_d = psm_pkg::PSM_RUN;
            end
         end
         psm_pkg::PSM_SLEEP: begin
            if (bus.wake_any) begin
               state_d = psm_pkg::PSM_STAB;
            end
         end
         psm_pkg::PSM_STOP: begin
            if (stop_wake) begin
               state_d = psm_pkg::PSM_STAB;
            end
         end
         psm_pkg::PSM_STAB: begin
            if (stab_done) begin
               state_d = psm_pkg::PSM_RUN;
            end
         end
         default: begin
            state_d = psm_pkg::PSM_RUN;
         end
      endcase
   end

   assign stab_start = (state_q != psm_pkg::PSM_STAB) && (state_d == psm_pkg::PSM_STAB);

   // Mode register; an internal reset drops straight back to run.
   always_ff @(posedge aclk) begin
      if (!aresetn || bus.int_reset) begin
         state_q <= psm_pkg::PSM_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Remember whether a STOP ended by the RC watchdog alone.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_wake_q <= 1'b0;
      end else if (stab_start) begin
         wdt_wake_q <= (state_q == psm_pkg::PSM_STOP) && rc_mode && bus.wake_wdt
                       && !bus.wake_ext;
      end
   end

   psm_stab_cnt #(
      .PRE_W(8)
   ) u_stab (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(stab_start),
      .presc_sel(ckctl_q[`PSM_CK_PRESC_MSB:`PSM_CK_PRESC_LSB]),
      .busy(),
      .done(stab_done)
   );

   // Completion pulses tell the core how to carry on after the wait.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus.resume <= 1'b0;
         bus.vector_req <= 1'b0;
         bus.wdt_vector <= 1'b0;
         bus.int_reset <= 1'b0;
      end else begin
         bus.resume <= 1'b0;
         bus.vector_req <= 1'b0;
         bus.wdt_vector <= 1'b0;
         bus.int_reset <= 1'b0;
         if (stab_done && state_q == psm_pkg::PSM_STAB) begin
            if (!bus.i_flag) begin
               bus.resume <= 1'b1;
            end else if (wdt_wake_q && ckctl_q[`PSM_CK_WDTRST_BIT]) begin
               bus.int_reset <= 1'b1;
            end else if (wdt_wake_q && bus.wdt_irq_en) begin
               bus.wdt_vector <= 1'b1;
            end else if (wdt_wake_q) begin
               bus.resume <= 1'b1;
            end else begin
               bus.vector_req <= 1'b1;
            end
         end
      end
   end

   // Mode code and clock gates other than sub_osc_en and rc_osc_en follow the next state so they line up with it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus.mode <= psm_pkg::PSM_MODE_RUN;
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         main_osc_en <= 1'b1;
         sub_osc_en <= 1'b1;
         rc_osc_en <= 1'b0;
         wdt_run <= 1'b1;
         bit_run <= 1'b1;
         timer_run <= 1'b1;
         sio_run <= 1'b1;
         uart0_run <= 1'b1;
         uart1_run <= 1'b1;
         state_hold <= 1'b0;
         pc_hold <= 1'b0;
      end else begin
         case (state_d)
            psm_pkg::PSM_SLEEP: bus.mode <= psm_pkg::PSM_MODE_SLEEP;
            psm_pkg::PSM_STOP: bus.mode <= psm_pkg::PSM_MODE_STOP;
            psm_pkg::PSM_STAB: bus.mode <= psm_pkg::PSM_MODE_STAB;
            default: bus.mode <= psm_pkg::PSM_MODE_RUN;
         endcase
         cpu_clk_en <= state_d == psm_pkg::PSM_RUN;
         periph_clk_en <= state_d != psm_pkg::PSM_STOP;
         main_osc_en <= state_d != psm_pkg::PSM_STOP;
         sub_osc_en <= 1'b1;
         rc_osc_en <= rc_mode;
         wdt_run <= (state_d == psm_pkg::PSM_RUN)
                    || (state_d == psm_pkg::PSM_STOP && rc_mode);
         bit_run <= state_d != psm_pkg::PSM_STOP;
         timer_run <= (state_d != psm_pkg::PSM_STOP) || bus.tmr_event_mode;
         sio_run <= (state_d == psm_pkg::PSM_RUN) || bus.sio_ext;
         uart0_run <= (state_d == psm_pkg::PSM_RUN) || bus.uart0_ext;
         uart1_run <= (state_d == psm_pkg::PSM_RUN) || bus.uart1_ext;
         state_hold <= state_d == psm_pkg::PSM_STOP;
         pc_hold <= state_d == psm_pkg::PSM_STOP;
      end
   end
endmodule : psm_dev_end

// *** core/psm_host_end.sv ***
// Processor-core end: AXI4-Lite registers that drive the power controller.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/10ps
`include "psm_consts.svh"
module psm_host_end #(
   parameter int ADDR_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   psm_if.core bus,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq_ext,
   input wire logic irq_timer_ec,
   input wire logic irq_watch,
   input wire logic irq_wdt,
   input wire logic irq_sio,
   input wire logic irq_uart,
   input wire logic irq_other
);
   logic aw_have_q;
   logic w_have_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic write_go;
   logic write_ok;
   logic [7:0] code_q;
   logic [7:0] ckctl_q;
   logic [6:1] ctrl_q;
   logic [7:4] stat_q;

   // True for the four word offsets that hold registers.
   function automatic logic reg_hit(input logic [3:0] a);
      return a == `PSM_REG_CODE || a == `PSM_REG_CKCTL || a == `PSM_REG_CTRL
             || a == `PSM_REG_STAT;
   endfunction : reg_hit

   assign write_go = aw_have_q && w_have_q && !s_axi_bvalid;
   assign write_ok = reg_hit(awaddr_q) && wstrb_q[0];

   // Write address and data are taken independently, one write at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr[3:0];
            s_axi_awready <= 1'b0;
         end else if (write_go) begin
            aw_have_q <= 1'b0;
         end else if (!aw_have_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (write_go) begin
            w_have_q <= 1'b0;
         end else if (!w_have_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write response follows one cycle after both halves are held.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PSM_AXI_OKAY;
      end else if (write_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= write_ok ? `PSM_AXI_OKAY : `PSM_AXI_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Byte writes to the code and clock registers become one-cycle strobes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus.code_wr <= 1'b0;
         bus.ckctl_wr <= 1'b0;
         bus.stop_exec <= 1'b0;
         bus.code_data <= `PSM_CODE_RST;
         bus.ckctl_data <= `PSM_CKCTL_RST;
         code_q <= `PSM_CODE_RST;
         ckctl_q <= `PSM_CKCTL_RST;
      end else begin
         bus.code_wr <= write_go && write_ok && awaddr_q == `PSM_REG_CODE;
         bus.ckctl_wr <= write_go && write_ok && awaddr_q == `PSM_REG_CKCTL;
         bus.stop_exec <= write_go && write_ok && awaddr_q == `PSM_REG_CTRL
                          && wdata_q[`PSM_CTRL_STOP_BIT];
         if (write_go && write_ok && awaddr_q == `PSM_REG_CODE) begin
            bus.code_data <= wdata_q[7:0];
            code_q <= wdata_q[7:0];
         end
         if (write_go && write_ok && awaddr_q == `PSM_REG_CKCTL) begin
            bus.ckctl_data <= wdata_q[7:0];
            ckctl_q <= wdata_q[7:0];
         end
         if (bus.int_reset) begin
            code_q <= `PSM_CODE_RST;
            ckctl_q <= `PSM_CKCTL_RST;
         end
      end
   end

   // Control levels; an internal reset from the controller clears them.
   always_ff @(posedge aclk) begin
      if (!aresetn || bus.int_reset) begin
         ctrl_q <= 6'h00;
      end else if (write_go && write_ok && awaddr_q == `PSM_REG_CTRL) begin
         ctrl_q <= wdata_q[6:1];
      end
   end

   assign bus.i_flag = ctrl_q[`PSM_CTRL_IFLAG_BIT];
   assign bus.wdt_irq_en = ctrl_q[`PSM_CTRL_WDTIE_BIT];
   assign bus.tmr_event_mode = ctrl_q[`PSM_CTRL_EVCNT_BIT];
   assign bus.sio_ext = ctrl_q[`PSM_CTRL_SIOEXT_BIT];
   assign bus.uart0_ext = ctrl_q[`PSM_CTRL_U0EXT_BIT];
   assign bus.uart1_ext = ctrl_q[`PSM_CTRL_U1EXT_BIT];

   // Sticky completion flags; a new event wins over a write-one clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= 4'h0;
      end else begin
         stat_q <= (stat_q & ~((write_go && write_ok && awaddr_q == `PSM_REG_STAT)
                               ? wdata_q[7:4] : 4'h0))
                   | {bus.int_reset, bus.wdt_vector, bus.vector_req, bus.resume};
      end
   end

   // Wake requests from the peripherals are registered toward the controller.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus.wake_any <= 1'b0;
         bus.wake_ext <= 1'b0;
         bus.wake_ec <= 1'b0;
         bus.wake_watch <= 1'b0;
         bus.wake_wdt <= 1'b0;
         bus.wake_sio <= 1'b0;
         bus.wake_uart <= 1'b0;
      end else begin
         bus.wake_any <= irq_ext || irq_timer_ec || irq_watch || irq_wdt || irq_sio
                         || irq_uart || irq_other;
         bus.wake_ext <= irq_ext;
         bus.wake_ec <= irq_timer_ec;
         bus.wake_watch <= irq_watch;
         bus.wake_wdt <= irq_wdt;
         bus.wake_sio <= irq_sio;
         bus.wake_uart <= irq_uart;
      end
   end

   // Reads answer one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `PSM_AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= reg_hit(s_axi_araddr[3:0]) ? `PSM_AXI_OKAY : `PSM_AXI_SLVERR;
         case (s_axi_araddr[3:0])
            `PSM_REG_CODE: s_axi_rdata <= {24'h0, code_q};
            `PSM_REG_CKCTL: s_axi_rdata <= {24'h0, ckctl_q};
            `PSM_REG_CTRL: s_axi_rdata <= {25'h0, ctrl_q, 1'b0};
            `PSM_REG_STAT: s_axi_rdata <= {24'h0, stat_q, 2'h0, bus.mode};
            default: s_axi_rdata <= 32'h0;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule : psm_host_end

// *** verif/psm_monitor.sv ***
// Checker of the link between the two ends of the power-saving controller.
`timescale 1ns/10ps
module psm_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic code_wr,
   input wire logic [7:0] code_data,
   input wire logic [7:0] ckctl_data,
   input wire logic stop_exec,
   input wire logic i_flag,
   input wire logic wake_any,
   input wire logic wake_ext,
   input wire logic wake_ec,
   input wire logic wake_watch,
   input wire logic wake_wdt,
   input wire logic wake_sio,
   input wire logic wake_uart,
   input wire psm_pkg::psm_mode_t mode,
   input wire logic resume,
   input wire logic vector_req,
   input wire logic wdt_vector,
   input wire logic int_reset
);
   logic run, slp, stp, stb, wk, pls;
   logic [19:0] cnt_q;
   logic [31:0] lim;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Mode decode, stop wake set and expected settle time.
   assign run = mode == psm_pkg::PSM_MODE_RUN;
   assign slp = mode == psm_pkg::PSM_MODE_SLEEP;
   assign stp = mode == psm_pkg::PSM_MODE_STOP;
   assign stb = mode == psm_pkg::PSM_MODE_STAB;
   assign wk = ckctl_data[5] ? (wake_ext | wake_wdt)
      : (wake_ext | wake_ec | wake_watch | wake_wdt | wake_sio | wake_uart);
   assign pls = resume | vector_req | wdt_vector | int_reset;
   assign lim = 32'd512 << ckctl_data[2:0];
   // Counts the cycles spent settling after a wake.
   always_ff @(posedge aclk) begin
      if (!aresetn || !stb) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 20'h1;
      end
   end
   sequence stab_exit;
      stb ##1 run;
   endsequence
   chk_sleep_entry: assert property (run && code_wr && code_data == 8'h0F |=> slp)
      else $error("sleep code did not halt the processor");
   chk_stop_entry: assert property (run && stop_exec && !code_wr
      && code_data == 8'h5A |=> stp)
      else $error("stop instruction with stop code did not stop");
   chk_run_stays: assert property (run && !(code_wr && code_data == 8'h0F)
      && !(stop_exec && code_data == 8'h5A) |=> run) else $error("left run without a code");
   chk_sleep_wake: assert property (slp && wake_any |=> stb)
      else $error("sleep did not end on an interrupt");
   chk_stop_wake: assert property (stp && wk |=> stb)
      else $error("stop did not end on a wake source");
   chk_stop_holds: assert property (stp && !wk |=> stp)
      else $error("stop ended without a wake source");
   chk_settle_len: assert property (stab_exit |-> cnt_q >= lim - 4 && cnt_q <= lim + 8)
      else $error("settle count has the wrong length");
   chk_exit_onehot: assert property (stab_exit
      |-> $onehot({resume, vector_req, wdt_vector, int_reset}))
      else $error("wake did not end in exactly one outcome");
   chk_flag_resume: assert property (stab_exit ##0 !i_flag |-> resume)
      else $error("clear interrupt flag did not resume");
   chk_pulse_exit: assert property (pls |-> run && $past(stb))
      else $error("outcome pulse outside the end of settling");
endmodule : psm_monitor

// *** verif/power_saving_mode_controller_test.sv ***
// Self-checking bench joining both ends of the power-saving controller.
`timescale 1ns/10ps
module power_saving_mode_controller_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic irq_ext = 1'b0, irq_timer_ec = 1'b0, irq_watch = 1'b0, irq_wdt = 1'b0;
   logic irq_sio = 1'b0, irq_uart = 1'b0, irq_other = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic cpu_clk_en, periph_clk_en, main_osc_en, sub_osc_en, rc_osc_en, wdt_run, bit_run;
   logic timer_run, sio_run, uart0_run, uart1_run, state_hold, pc_hold;
   int mismatches = 0;
   int checked = 0;
   psm_if link ();
   // Free-running 25 MHz clock.
   always #20 aclk = ~aclk;
   psm_host_end psm_host_end_i (.aclk, .aresetn, .bus(link), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_ext, .irq_timer_ec, .irq_watch, .irq_wdt,
      .irq_sio, .irq_uart, .irq_other);
   psm_dev_end psm_dev_end_i (.aclk, .aresetn, .bus(link), .cpu_clk_en, .periph_clk_en,
      .main_osc_en, .sub_osc_en, .rc_osc_en, .wdt_run, .bit_run, .timer_run, .sio_run,
      .uart0_run, .uart1_run, .state_hold, .pc_hold);
   psm_monitor mon_i (.aclk, .aresetn, .code_wr(link.code_wr), .code_data(link.code_data),
      .ckctl_data(link.ckctl_data), .stop_exec(link.stop_exec), .i_flag(link.i_flag),
      .wake_any(link.wake_any), .wake_ext(link.wake_ext), .wake_ec(link.wake_ec),
      .wake_watch(link.wake_watch), .wake_wdt(link.wake_wdt), .wake_sio(link.wake_sio),
      .wake_uart(link.wake_uart), .mode(link.mode), .resume(link.resume),
      .vector_req(link.vector_req), .wdt_vector(link.wdt_vector), .int_reset(link.int_reset));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   task automatic late(input int n);
      if (n >= 2000) begin
         mismatches++;
         test_done();
      end
   endtask : late
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
         input logic [1:0] er);
      logic aw, w;
      int n;
      aw = 1'b1;
      w = 1'b1;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while ((aw || w) && n < 2000) begin
         @(posedge aclk);
         n++;
         aw = aw && s_axi_awready !== 1'b1;
         w = w && s_axi_wready !== 1'b1;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 2000);
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(s_axi_bresp), 32'(er));
      late(n);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 2000);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 2000);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      late(n);
   endtask : rd
   task automatic rc(input logic [3:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(nm, d, exp);
   endtask : rc
   // Waits for a mode, sampled just after each edge.
   task automatic wait_mode(input psm_pkg::psm_mode_t m);
      int n;
      n = 0;
      while (link.mode !== m && n < 2000) begin
         @(posedge aclk);
         #1;
         n++;
      end
      late(n);
   endtask : wait_mode
   // Runs settling to its end and returns the outcome pulses of the first run cycle after it.
   task automatic settle(output logic [3:0] p);
      wait_mode(psm_pkg::PSM_MODE_STAB);
      wait_mode(psm_pkg::PSM_MODE_RUN);
      p = {link.int_reset, link.wdt_vector, link.vector_req, link.resume};
      @(posedge aclk);
      {irq_other, irq_timer_ec, irq_watch, irq_wdt} <= 4'h0;
   endtask : settle
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      rc(4'h4, 32'h0, "ckctl reset");
      chk("run gates", 32'({cpu_clk_en, periph_clk_en, main_osc_en, rc_osc_en}), 32'hE);
      rd(4'h2, d, r);
      chk("unmapped", 32'({r, d[7:0]}), 32'h200);
      wr(4'h0, 32'h0F, 4'h0, 2'h2);
      wr(4'h0, 32'h33, 4'hF, 2'h0);
      wr(4'h8, 32'h01, 4'hF, 2'h0);
      repeat (3) @(posedge aclk);
      rc(4'h0, 32'h33, "odd code kept");
      chk("odd code mode", 32'(link.mode), 32'(psm_pkg::PSM_MODE_RUN));
      $display("test reset done");
   endtask : t_reset
   task automatic t_sleep();
      logic [3:0] p;
      wr(4'h8, 32'h02, 4'hF, 2'h0);
      wr(4'h0, 32'h0F, 4'hF, 2'h0);
      wait_mode(psm_pkg::PSM_MODE_SLEEP);
      chk("sleep gates", 32'({cpu_clk_en, periph_clk_en, main_osc_en, bit_run,
         wdt_run}), 32'hE);
      @(posedge aclk);
      irq_other <= 1'b1;
      settle(p);
      chk("sleep outcome", 32'(p), 32'h2);
      rc(4'h8, 32'h02, "ctrl kept");
      rc(4'hC, 32'h20, "status");
      $display("test sleep done");
   endtask : t_sleep
   task automatic t_stop();
      logic [3:0] p;
      wr(4'h0, 32'h5A, 4'hF, 2'h0);
      wr(4'h8, 32'h19, 4'hF, 2'h0);
      wait_mode(psm_pkg::PSM_MODE_STOP);
      chk("stop gates", 32'({cpu_clk_en, periph_clk_en, main_osc_en,
         sub_osc_en, timer_run, sio_run, uart0_run, uart1_run, wdt_run, state_hold, pc_hold}),
         32'h0E3);
      @(posedge aclk);
      irq_other <= 1'b1;
      repeat (10) @(posedge aclk);
      chk("stop ignores other", 32'(link.mode), 32'(psm_pkg::PSM_MODE_STOP));
      irq_timer_ec <= 1'b1;
      settle(p);
      chk("stop outcome", 32'(p), 32'h1);
      $display("test stop done");
   endtask : t_stop
   task automatic t_rc(input logic [31:0] ck, input logic [31:0] ctrl, input logic [3:0] exp);
      logic [3:0] p;
      wr(4'h4, ck, 4'hF, 2'h0);
      wr(4'h0, 32'h5A, 4'hF, 2'h0);
      wr(4'h8, ctrl, 4'hF, 2'h0);
      wait_mode(psm_pkg::PSM_MODE_STOP);
      chk("rc gates", 32'({rc_osc_en, wdt_run, main_osc_en}), 32'h6);
      @(posedge aclk);
      irq_watch <= 1'b1;
      repeat (10) @(posedge aclk);
      chk("rc ignores watch", 32'(link.mode), 32'(psm_pkg::PSM_MODE_STOP));
      irq_wdt <= 1'b1;
      settle(p);
      chk("rc outcome", 32'(p), 32'(exp));
      $display("test rc stop done");
   endtask : t_rc
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_sleep();
      t_stop();
      t_rc(32'h30, 32'h03, 4'h8);
      rc(4'h4, 32'h0, "ckctl after internal reset");
      t_rc(32'h20, 32'h07, 4'h4);
      test_done();
   end
endmodule : power_saving_mode_controller_test
